// ==== rtl/pfs_defines.svh ====
// Offsets, field positions, reset values and pin numbers of the pin
// function block.
// Assumes it is included by bare name, after the package is compiled.
////////////////////////////////////////////////////////////////////////////
// What this block does
// R1: Debug active: pin 36 only test data out.
// R2: Debug active: pin 37 only test data in.
// R3: Debug active: pin 38 only mode select line.
// R4: Debug active: pin 39 only test clock.
// R5: Low test reset resets debug logic.
// R6: Any-trip monitor is OR of both trips.
// R7: Any pin selectable as capture input.
// R8: Capture output on all pins but 36, 37.
// R9: Each amplifier: two 3-bit eight-way selectors.
// R10: Code 0 selects ground.
// R11: Code 1 selects reference converter one.
// R12: Code 2 selects per-amplifier special nodes.
// R13: Code 3: channel 0 positive, 1..3 negative.
// R14: Code 4: channels 6/7, 2/3, 4/5.
// R15: Code 5: channel 8 positive, 9..11 negative.
// R16: Code 6: channels 10/5, 10/11, 12/13.
// R17: Code 7: channels 4/3, 9/1, 14/15.
// R18: Reset: pins 0-15 analog, no pulls.
// R19: Reset: pins 16-33, 36-39 plain, floating.
// R20: Reset: pins 34, 35 plain with pull-up.
// R21: Reset: pin 40 plain boot with pull-up.
// R22: Pins 18-29 routed to power stage module.
// R23: One function per pin; debug overrides.
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH
`define PFS_NPIN 41
`define PFS_ANA_LAST 15
`define PFS_HV_LO 18
`define PFS_HV_HI 29
`define PFS_PU_PIN_A 34
`define PFS_PU_PIN_B 35
`define PFS_PIN_TDO 36
`define PFS_PIN_TDI 37
`define PFS_PIN_TMS 38
`define PFS_PIN_TCK 39
`define PFS_PIN_BOOT 40
`define PFS_CAP_SEL_OFS 8'hC0
`define PFS_PGA_SEL_OFS 8'hC4
`define PFS_STATUS_OFS 8'hC8
`define PFS_PU_BIT 3
`define PFS_PD_BIT 4
`define PFS_CFG_W 5
`define PFS_PGA_W 18
`define PFS_AMPS 3
`endif

// ==== rtl/pfs_pkg.sv ====
// Types of the pin function block: pin functions and amplifier sources.
// Assumes nothing of its surroundings.
////////////////////////////////////////////////////////////////////////////
package pfs_pkg;
  typedef enum logic [2:0] {
    FN_GPIO = 3'h0, FN_ANALOG = 3'h1, FN_CAP_OUT = 3'h2,
    FN_TRIP = 3'h3, FN_PERIPH = 3'h4
  } pfs_func_t;
  typedef enum logic [2:0] {
    SEL_GND = 3'h0, SEL_REF1 = 3'h1, SEL_MISC = 3'h2, SEL_G3 = 3'h3,
    SEL_G4 = 3'h4, SEL_G5 = 3'h5, SEL_G6 = 3'h6, SEL_G7 = 3'h7
  } pfs_sel_t;
  typedef enum logic [4:0] {
    SRC_GND = 5'h00, SRC_REF_CONV1 = 5'h01, SRC_REF_CONV2 = 5'h02,
    SRC_REF_CONV3 = 5'h03, SRC_ANALOG_TEST = 5'h04, SRC_CORE_SUPPLY = 5'h05,
    SRC_TEMP0 = 5'h06, SRC_TEMP1 = 5'h07, SRC_CH0 = 5'h10
  } pfs_src_t;
endpackage : pfs_pkg

// ==== rtl/pfs_pin_mux.sv ====
// Pin function multiplexer, debug override and amplifier input selectors.
// Assumes pads, the debug port, peripherals and the power stage sit
// outside, and that clk runs at 50 MHz.
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`include "pfs_defines.svh"
////////////////////////////////////////////////////////////////////////////
module pfs_pin_mux (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Package pads
  input wire logic [`PFS_NPIN-1:0] pad_in,
  output logic [`PFS_NPIN-1:0] pad_out,
  output logic [`PFS_NPIN-1:0] pad_oe_n,
  output logic [`PFS_NPIN-1:0] pad_pull_up,
  output logic [`PFS_NPIN-1:0] pad_pull_dn,
  output logic [`PFS_NPIN-1:0] pad_analog_en,
  // Internal pins towards the power stage
  input wire logic [`PFS_HV_HI-`PFS_HV_LO:0] hv_in,
  output logic [`PFS_HV_HI-`PFS_HV_LO:0] hv_out,
  output logic [`PFS_HV_HI-`PFS_HV_LO:0] hv_oe_n,
  // General-purpose controller
  input wire logic [`PFS_NPIN-1:0] gpio_do,
  input wire logic [`PFS_NPIN-1:0] gpio_oe,
  output logic [`PFS_NPIN-1:0] gpio_di,
  // Other peripheral functions
  input wire logic [`PFS_NPIN-1:0] periph_do,
  input wire logic [`PFS_NPIN-1:0] periph_oe,
  // Event capture unit
  input wire logic cap_out_sig,
  output logic cap_in,
  // Trip monitors
  input wire logic trip_zone0_monitor_out,
  input wire logic trip_zone1_monitor_out,
  output logic trip_zone_any_monitor_out,
  // Debug port
  input wire logic trst_n_pin,
  input wire logic dbg_tdo,
  input wire logic dbg_tms_out,
  input wire logic dbg_tms_oe,
  output logic dbg_tdi,
  output logic dbg_tms_in,
  output logic dbg_tck,
  output logic dbg_rst_n,
  output logic dbg_active,
  // Amplifier input sources, five bits per amplifier
  output logic [14:0] amp_positive_input,
  output logic [14:0] amp_negative_input
);

  localparam int NP = `PFS_NPIN;
  localparam int HVL = `PFS_HV_LO;

  logic [`PFS_CFG_W-1:0] cfg_r [NP];
  logic [5:0] cap_sel_r;
  logic [`PFS_PGA_W-1:0] pga_r;
  logic [`PFS_PGA_W-1:0] pga_nxt;
  logic [NP-1:0] raw_in;
  logic [NP-1:0] sync1_r;
  logic [NP-1:0] sync2_r;
  logic trst1_r;
  logic trst2_r;
  logic cap_in_r;
  logic [31:0] rdata_r;
  logic [14:0] amp_pos_r;
  logic [14:0] amp_neg_r;

  ////////////////////////////////////////////////////////////////////////
  // Functions.

  // Reset function and pulls of one pin.
  function automatic logic [`PFS_CFG_W-1:0] reset_cfg(input int i);
    logic [`PFS_CFG_W-1:0] c;
    c = '0;
    if (i <= `PFS_ANA_LAST) begin
      c[2:0] = pfs_pkg::FN_ANALOG; // R18
    end else begin
      c[2:0] = pfs_pkg::FN_GPIO; // R19
    end
    if (i == `PFS_PU_PIN_A || i == `PFS_PU_PIN_B) begin
      c[`PFS_PU_BIT] = 1'b1; // R20
    end
    if (i == `PFS_PIN_BOOT) begin
      c[`PFS_PU_BIT] = 1'b1; // R21
    end
    return c;
  endfunction : reset_cfg

  // A function code that a pin cannot take is refused and the old one kept.
  function automatic logic func_ok(input int i, input logic [2:0] f);
    logic ok;
    ok = 1'b0;
    case (f)
      pfs_pkg::FN_GPIO: ok = 1'b1;
      pfs_pkg::FN_TRIP: ok = 1'b1;
      pfs_pkg::FN_PERIPH: ok = 1'b1;
      pfs_pkg::FN_ANALOG: ok = (i <= `PFS_ANA_LAST);
      pfs_pkg::FN_CAP_OUT: ok = (i != `PFS_PIN_TDO) &&
        (i != `PFS_PIN_TDI); // R8
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : func_ok

  function automatic logic [4:0] chan(input logic [3:0] n);
    return pfs_pkg::SRC_CH0 | {1'b0, n};
  endfunction : chan

  // Eight-way source table of one amplifier input.
  function automatic logic [4:0] pga_src(input logic [1:0] amp,
                                         input logic neg,
                                         input logic [2:0] code);
    logic [4:0] s;
    s = pfs_pkg::SRC_GND;
    case (code)
      pfs_pkg::SEL_GND: s = pfs_pkg::SRC_GND; // R10
      pfs_pkg::SEL_REF1: s = pfs_pkg::SRC_REF_CONV1; // R11
      pfs_pkg::SEL_MISC: begin // R12
        case (amp)
          2'h0: s = neg ? pfs_pkg::SRC_REF_CONV3 : pfs_pkg::SRC_REF_CONV2;
          2'h1: s = neg ? pfs_pkg::SRC_CORE_SUPPLY : pfs_pkg::SRC_ANALOG_TEST;
          default: s = neg ? pfs_pkg::SRC_TEMP0 : pfs_pkg::SRC_TEMP1;
        endcase
      end
      pfs_pkg::SEL_G3: s = neg ? chan({2'h0, amp} + 4'h1) : chan(4'h0); // R13
      pfs_pkg::SEL_G4: begin // R14
        case (amp)
          2'h0: s = chan(neg ? 4'h7 : 4'h6);
          2'h1: s = chan(neg ? 4'h3 : 4'h2);
          default: s = chan(neg ? 4'h5 : 4'h4);
        endcase
      end
      pfs_pkg::SEL_G5: s = neg ? chan({2'h0, amp} + 4'h9) : chan(4'h8); // R15
      pfs_pkg::SEL_G6: begin // R16
        case (amp)
          2'h0: s = chan(neg ? 4'h5 : 4'hA);
          2'h1: s = chan(neg ? 4'hB : 4'hA);
          default: s = chan(neg ? 4'hD : 4'hC);
        endcase
      end
      default: begin // R17
        case (amp)
          2'h0: s = chan(neg ? 4'h3 : 4'h4);
          2'h1: s = chan(neg ? 4'h1 : 4'h9);
          default: s = chan(neg ? 4'hF : 4'hE);
        endcase
      end
    endcase
    return s;
  endfunction : pga_src

  ////////////////////////////////////////////////////////////////////////
  // Register decode.

  wire [5:0] widx = reg_addr[7:2];
  wire aligned = (reg_addr[1:0] == 2'h0);
  wire is_pin = aligned && (widx < 6'(NP));
  wire is_cap = (reg_addr == `PFS_CAP_SEL_OFS);
  wire is_pga = (reg_addr == `PFS_PGA_SEL_OFS);
  wire is_stat = (reg_addr == `PFS_STATUS_OFS);
  wire pin_wr = reg_wr && is_pin;
  wire cap_wr = reg_wr && is_cap && (reg_wdata[5:0] < 6'(NP));
  wire pga_wr = reg_wr && is_pga;
  wire [2:0] wfunc = reg_wdata[2:0];
  wire [`PFS_CFG_W-1:0] pin_rd = is_pin ? cfg_r[widx] : '0;
  wire [31:0] rd_mux =
    is_pin ? {27'h0, pin_rd} :
    is_cap ? {26'h0, cap_sel_r} :
    is_pga ? {14'h0, pga_r} :
    is_stat ? {29'h0, cap_in_r, trip_zone_any_monitor_out, trst2_r} :
    32'h0;

  assign pga_nxt = pga_wr ? reg_wdata[`PFS_PGA_W-1:0] : pga_r;
  assign trip_zone_any_monitor_out =
    trip_zone0_monitor_out | trip_zone1_monitor_out; // R6

  ////////////////////////////////////////////////////////////////////////
  // Per-pin selection.

  for (genvar i = 0; i < NP; i++) begin : g_pin
    localparam bit HV = (i >= `PFS_HV_LO) && (i <= `PFS_HV_HI);
    localparam bit DBG = (i >= `PFS_PIN_TDO) && (i <= `PFS_PIN_TCK);
    wire [2:0] fn = cfg_r[i][2:0];
    wire hit = pin_wr && (widx == 6'(i));
    wire [2:0] keep_fn = func_ok(i, wfunc) ? wfunc : fn; // R8
    wire [`PFS_CFG_W-1:0] cfg_nxt = hit ?
      {reg_wdata[`PFS_PD_BIT], reg_wdata[`PFS_PU_BIT], keep_fn} :
      cfg_r[i];
    // Exactly one function drives the pin; unused codes leave it idle.
    wire fn_out = (fn == pfs_pkg::FN_GPIO) ? gpio_do[i] :
      (fn == pfs_pkg::FN_CAP_OUT) ? cap_out_sig :
      (fn == pfs_pkg::FN_TRIP) ? trip_zone_any_monitor_out :
      (fn == pfs_pkg::FN_PERIPH) ? periph_do[i] : 1'b0; // R23
    wire fn_oe = (fn == pfs_pkg::FN_GPIO) ? gpio_oe[i] :
      (fn == pfs_pkg::FN_PERIPH) ? periph_oe[i] :
      (fn == pfs_pkg::FN_CAP_OUT) || (fn == pfs_pkg::FN_TRIP);
    wire ovr = DBG && trst2_r; // R23
    wire dbg_o = (i == `PFS_PIN_TDO) ? dbg_tdo :
      (i == `PFS_PIN_TMS) ? dbg_tms_out : 1'b0; // R1 R3
    wire dbg_oe = (i == `PFS_PIN_TDO) ? 1'b1 :
      (i == `PFS_PIN_TMS) ? dbg_tms_oe : 1'b0; // R1 R2 R3 R4
    wire drv_o = ovr ? dbg_o : fn_out;
    wire drv_oe = ovr ? dbg_oe : fn_oe;
    wire ana = (fn == pfs_pkg::FN_ANALOG) && !ovr;
    wire pu = cfg_r[i][`PFS_PU_BIT] && !ana && !ovr;
    wire pd = cfg_r[i][`PFS_PD_BIT] && !ana && !ovr && !pu;

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        cfg_r[i] <= reset_cfg(i); // R18 R19 R20 R21
      end else begin
        cfg_r[i] <= cfg_nxt;
      end
    end

    if (HV) begin : g_hv
      // These pins never reach the package.
      assign hv_out[i-HVL] = drv_o; // R22
      assign hv_oe_n[i-HVL] = !drv_oe;
      assign raw_in[i] = hv_in[i-HVL];
      assign pad_out[i] = 1'b0;
      assign pad_oe_n[i] = 1'b1; // R22
      assign pad_pull_up[i] = 1'b0;
      assign pad_pull_dn[i] = 1'b0;
      assign pad_analog_en[i] = 1'b0;
    end else begin : g_pad
      assign raw_in[i] = pad_in[i];
      assign pad_out[i] = drv_o;
      assign pad_oe_n[i] = !drv_oe;
      assign pad_pull_up[i] = pu;
      assign pad_pull_dn[i] = pd;
      assign pad_analog_en[i] = ana;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers and debug pass-through.

  // The test data in, mode select and clock lines are clocked by the probe, so they pass unsynchronised; test reset goes through two flops.
  assign dbg_tdi = pad_in[`PFS_PIN_TDI]; // R2
  assign dbg_tms_in = pad_in[`PFS_PIN_TMS]; // R3
  assign dbg_tck = pad_in[`PFS_PIN_TCK]; // R4
  assign dbg_rst_n = trst2_r; // R5
  assign dbg_active = trst2_r;
  assign gpio_di = sync2_r;
  assign cap_in = cap_in_r;
  assign reg_rdata = rdata_r;
  assign amp_positive_input = amp_pos_r;
  assign amp_negative_input = amp_neg_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      trst1_r <= 1'b0;
      trst2_r <= 1'b0;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
      trst1_r <= trst_n_pin;
      trst2_r <= trst1_r; // R5
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cap_sel_r <= 6'h00;
      cap_in_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      if (cap_wr) begin
        cap_sel_r <= reg_wdata[5:0];
      end
      cap_in_r <= sync2_r[cap_sel_r]; // R7
      rdata_r <= reg_rd ? rd_mux : 32'h0;
    end
  end

  // Sources follow the selector in the same edge that stores it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pga_r <= '0;
      amp_pos_r <= '0;
      amp_neg_r <= '0;
    end else begin
      pga_r <= pga_nxt;
      for (int a = 0; a < `PFS_AMPS; a++) begin
        amp_pos_r[a*5 +: 5] <= pga_src(2'(a), 1'b0, pga_nxt[a*6 +: 3]); // R9
        amp_neg_r[a*5 +: 5] <= pga_src(2'(a), 1'b1, pga_nxt[a*6+3 +: 3]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence trst_low3;
    !trst_n_pin [*3];
  endsequence

  sequence pga_write(logic [17:0] v);
    pga_wr && reg_wdata[17:0] == v;
  endsequence

  trip_or_a: assert property ( // R6
    trip_zone_any_monitor_out ==
      (trip_zone0_monitor_out || trip_zone1_monitor_out))
    else $error("trip monitor is not the OR of both trips");
  tdo_ovr_a: assert property ( // R1
    dbg_active |-> !pad_oe_n[`PFS_PIN_TDO] &&
      pad_out[`PFS_PIN_TDO] == dbg_tdo)
    else $error("pin 36 not test data out in debug");
  tdi_ovr_a: assert property ( // R2
    dbg_active |-> pad_oe_n[`PFS_PIN_TDI] && !pad_pull_up[`PFS_PIN_TDI])
    else $error("pin 37 driven in debug");
  tms_ovr_a: assert property ( // R3
    dbg_active |-> pad_oe_n[`PFS_PIN_TMS] == !dbg_tms_oe)
    else $error("pin 38 not mode select in debug");
  tck_ovr_a: assert property ( // R4
    dbg_active |-> pad_oe_n[`PFS_PIN_TCK])
    else $error("pin 39 driven in debug");
  dbg_rst_a: assert property ( // R5
    trst_low3 |-> !dbg_rst_n && !dbg_active)
    else $error("debug logic not held in reset");
  cap_pin_a: assert property ( // R8
    pin_wr && widx == 6'(`PFS_PIN_TDI) && wfunc == pfs_pkg::FN_CAP_OUT
      |=> cfg_r[`PFS_PIN_TDI][2:0] != pfs_pkg::FN_CAP_OUT)
    else $error("capture output taken by pin 37");
  // The selector is taken from the write data, as the stored one is still the old one in the write cycle.
  cap_in_a: assert property ( // R7
    cap_wr ##1 !cap_wr [*3] |-> cap_in == $past(raw_in[reg_wdata[5:0]], 3))
    else $error("capture input not from selected pin");
  pga_gnd_a: assert property ( // R10
    pga_write(18'h0) |=> amp_positive_input == 15'h0 &&
      amp_negative_input == 15'h0)
    else $error("code 0 does not select ground");
  pga_g5_a: assert property ( // R15
    pga_write(18'h2DB6D) |=> amp_positive_input == 15'h6318 &&
      amp_negative_input == 15'h6F59)
    else $error("code 5 routing wrong");
  boot_pull_a: assert property ( // R20
    $fell(rst) |-> pad_pull_up[`PFS_PU_PIN_A] &&
      pad_pull_up[`PFS_PIN_BOOT] && pad_analog_en[0])
    else $error("reset pulls or functions wrong");
  hv_pad_a: assert property ( // R22
    pad_oe_n[`PFS_HV_HI:`PFS_HV_LO] == '1)
    else $error("power stage pin reached the package");

endmodule : pfs_pin_mux

// ==== verification/pfs_pin_world.sv ====
// Pad-side world model: external drivers, pulls and the power stage pins.
// Assumes the pin mux drives pads and power stage pins with low enables.
`timescale 1ns/10ps
`include "pfs_defines.svh"
////////////////////////////////////////////////////////////////////////////
module pfs_pin_world (
  // Clock
  input wire logic clk,
  // Pin mux side
  input wire logic [`PFS_NPIN-1:0] pad_out,
  input wire logic [`PFS_NPIN-1:0] pad_oe_n,
  input wire logic [`PFS_NPIN-1:0] pad_pull_up,
  input wire logic [`PFS_NPIN-1:0] pad_pull_dn,
  input wire logic [11:0] hv_out,
  input wire logic [11:0] hv_oe_n,
  output logic [`PFS_NPIN-1:0] pad_in,
  output logic [11:0] hv_in,
  // External drivers set by the bench
  input wire logic [`PFS_NPIN-1:0] ext_val,
  input wire logic [`PFS_NPIN-1:0] ext_en
);
  logic [`PFS_NPIN-1:0] float_r;
  // A pin nobody drives or pulls toggles every cycle, so that a design
  // reading a floating pin cannot pass by luck.
  initial float_r = '0;
  always @(posedge clk) float_r <= ~float_r;
  assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_val)
    | (pad_oe_n & ~ext_en & (pad_pull_up | (~pad_pull_dn & float_r)));
  // The power stage echoes what it is given back on its inputs.
  assign hv_in = (~hv_oe_n & hv_out) | (hv_oe_n & float_r[11:0]);
endmodule : pfs_pin_world

// ==== verification/test_pfs_pin_mux.sv ====
// Self-checking bench of the pin function block over its register port.
// Assumes the pad world model and the design files are compiled first.
`timescale 1ns/10ps
`include "pfs_defines.svh"
////////////////////////////////////////////////////////////////////////////
module test_pfs_pin_mux;
  logic clk, rst, reg_wr, reg_rd, cap_out_sig, cap_in, tz0, tz1, any;
  logic trst_n, tdo, tms_o, tms_oe, tdi, tms_i, tck, dbg_rst_n, dbg_act;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d, e;
  logic [40:0] pad_in, pad_out, pad_oe_n, pull_up, pull_dn, ana_en;
  logic [40:0] gpio_do, gpio_oe, gpio_di, per_do, per_oe, ext_val, ext_en;
  logic [11:0] hv_in, hv_out, hv_oe_n;
  logic [14:0] amp_p, amp_n;
  int fails, num_checks, cyc;
  // Rows: positive then negative input of amplifiers 0, 1, 2; index: code.
  localparam logic [4:0] PT [0:5][0:7] = '{
    '{5'h00, 5'h01, 5'h02, 5'h10, 5'h16, 5'h18, 5'h1A, 5'h14},
    '{5'h00, 5'h01, 5'h03, 5'h11, 5'h17, 5'h19, 5'h15, 5'h13},
    '{5'h00, 5'h01, 5'h04, 5'h10, 5'h12, 5'h18, 5'h1A, 5'h19},
    '{5'h00, 5'h01, 5'h05, 5'h12, 5'h13, 5'h1A, 5'h1B, 5'h11},
    '{5'h00, 5'h01, 5'h07, 5'h10, 5'h14, 5'h18, 5'h1C, 5'h1E},
    '{5'h00, 5'h01, 5'h06, 5'h13, 5'h15, 5'h1B, 5'h1D, 5'h1F}};

  pfs_pin_mux uut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pad_pull_up(pull_up), .pad_pull_dn(pull_dn),
    .pad_analog_en(ana_en), .hv_in(hv_in), .hv_out(hv_out),
    .hv_oe_n(hv_oe_n), .gpio_do(gpio_do), .gpio_oe(gpio_oe),
    .gpio_di(gpio_di), .periph_do(per_do), .periph_oe(per_oe),
    .cap_out_sig(cap_out_sig), .cap_in(cap_in),
    .trip_zone0_monitor_out(tz0), .trip_zone1_monitor_out(tz1),
    .trip_zone_any_monitor_out(any), .trst_n_pin(trst_n), .dbg_tdo(tdo),
    .dbg_tms_out(tms_o), .dbg_tms_oe(tms_oe), .dbg_tdi(tdi),
    .dbg_tms_in(tms_i), .dbg_tck(tck), .dbg_rst_n(dbg_rst_n),
    .dbg_active(dbg_act), .amp_positive_input(amp_p),
    .amp_negative_input(amp_n));

  pfs_pin_world world (.clk(clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pull_up(pull_up), .pad_pull_dn(pull_dn), .hv_out(hv_out),
    .hv_oe_n(hv_oe_n), .pad_in(pad_in), .hv_in(hv_in), .ext_val(ext_val),
    .ext_en(ext_en));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task results;
    $display("Checks %0d, errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  // A hang is cut short well past the 170 or so cycles the run needs.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      results;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, reg_wr, reg_rd, cap_out_sig, tz0, tz1} = 6'h20;
    {trst_n, tdo, tms_o, tms_oe} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    {gpio_do, gpio_oe, per_do, per_oe, ext_val, ext_en} = '0;
    fails = 0;
    num_checks = 0;
    cyc = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int n = 0; n < 41; n++) begin
      e = (n <= 15) ? 32'h1 : (n == 34 || n == 35 || n == 40) ? 32'h8 : 0;
      rd(8'(4 * n));
      chk(d, e);
      chk(pull_up[n], e[3]);
      chk(ana_en[n], e[0]);
    end
    wr(8'hCC, 32'hFFFF_FFFF);
    rd(8'hCC);
    chk(d, 32'h0);
    for (int c = 0; c < 8; c++) begin
      e = 0;
      for (int a = 0; a < 3; a++) e |= (c | ((7 - c) << 3)) << (6 * a);
      wr(8'hC4, e);
      for (int a = 0; a < 3; a++) begin
        chk(amp_p[5*a+:5], PT[2*a][c]);
        chk(amp_n[5*a+:5], PT[2*a+1][7-c]);
      end
    end
    wr(8'hC4, 32'h2DB6D);
    chk(amp_p, 32'({PT[4][5], PT[2][5], PT[0][5]}));
    chk(amp_n, 32'({PT[5][5], PT[3][5], PT[1][5]}));
    wr(8'hC4, 32'h0);
    chk({amp_p, amp_n}, 32'h0);
    wr(8'h80, 32'h3);
    for (int t = 0; t < 4; t++) begin
      @(posedge clk);
      {tz1, tz0} <= 2'(t);
      #1;
      chk(any, 32'(t != 0));
      chk(pad_out[32], 32'(t != 0));
    end
    rd(8'hC8);
    chk(d[1], 1'b1);
    wr(8'hC0, 32'd33);
    wr(8'hC0, 32'd41);
    rd(8'hC0);
    chk(d, 32'd33);
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk);
      ext_en[33] <= 1'b1;
      ext_val[33] <= 1'(v);
      step(4);
      chk(cap_in, 32'(v));
    end
    wr(8'hC0, 32'd40);
    step(4);
    chk(cap_in, 1'b1);
    wr(8'h78, 32'h2);
    wr(8'h90, 32'h2);
    rd(8'h90);
    chk(d, 32'h0);
    wr(8'h94, 32'h2);
    rd(8'h94);
    chk(d, 32'h0);
    @(posedge clk);
    cap_out_sig <= 1'b1;
    gpio_oe[36] <= 1'b1;
    gpio_do[36] <= 1'b1;
    gpio_oe[20] <= 1'b1;
    gpio_do[20] <= 1'b1;
    per_oe[31] <= 1'b1;
    per_do[31] <= 1'b1;
    wr(8'h7C, 32'h4);
    chk({pad_out[30], pad_oe_n[30]}, 2'b10);
    chk({pad_out[31], pad_oe_n[31]}, 2'b10);
    chk({pad_out[36], pad_oe_n[36], dbg_act}, 3'b100);
    chk({hv_out[2], hv_oe_n[2], pad_oe_n[20]}, 3'b101);
    step(3);
    chk(gpio_di[20], 1'b1);
    wr(8'h40, 32'h10);
    chk({pull_dn[16], pull_up[16]}, 2'b10);
    @(posedge clk);
    trst_n <= 1'b1;
    {tms_oe, tms_o} <= 2'b11;
    ext_en[39:37] <= 3'b111;
    ext_val[39:37] <= 3'b101;
    step(3);
    chk({dbg_act, dbg_rst_n}, 2'b11);
    chk({pad_out[36], pad_oe_n[36]}, 2'b00);
    chk({tdi, pad_oe_n[37]}, 2'b11);
    chk({pad_out[38], pad_oe_n[38]}, 2'b10);
    chk(tms_i, 1'b1);
    chk({tck, pad_oe_n[39]}, 2'b11);
    @(posedge clk);
    trst_n <= 1'b0;
    step(3);
    chk({dbg_act, dbg_rst_n}, 2'b00);
    chk({pad_out[36], pad_oe_n[36]}, 2'b10);
    results;
  end
endmodule : test_pfs_pin_mux
